// ==== src/oar_core.sv ====
// operand address generation, immediate decode, prefetch and repeat control
module oar_core (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_prog_ready,
	input  wire logic [15:0] i_prog_word,
	input  wire logic        i_data_ready,
	input  wire logic [15:0] i_data_rdata,
	output logic      [15:0] o_prog_addr,
	output logic             o_prog_rd,
	output logic      [15:0] o_data_addr,
	output logic             o_data_rd,
	output logic             o_data_external,
	output logic      [15:0] o_operand,
	output logic             o_operand_valid,
	output logic             o_multi_iter,
	output logic      [2:0]  o_multi_kind,
	output logic             o_int_mask,
	output logic      [15:0] o_repeat_counter,
	output logic      [8:0]  o_page_pointer,
	output logic      [2:0]  o_addr_reg_selector
);
	oar_pkg::oar_state_e state_reg;
	oar_pkg::oar_state_e state_next;

	logic [15:0] pc_reg;
	logic        pend_reg;
	logic        pf_valid_reg;
	logic [15:0] pf_word_reg;
	logic [15:0] ir_reg;
	logic [8:0]  dp_reg;
	logic [1:0]  pad_reg;
	logic        rpt_pend_reg;
	logic [15:0] iss_left_reg;
	logic [15:0] prog_addr_reg;
	logic        prog_rd_reg;
	logic [15:0] data_addr_reg;
	logic        data_rd_reg;
	logic        data_ext_reg;
	logic [15:0] operand_reg;
	logic        operand_valid_reg;
	logic        multi_iter_reg;
	logic [2:0]  multi_kind_reg;
	logic        int_mask_reg;
	logic [15:0] rpt_cnt_reg;
	logic [2:0]  arp_out_reg;

	wire [2:0]  arp_now;
	wire [15:0] cur_ar;
	wire [15:0] rpt_cnt;
	wire        rpt_active;

	// decode always looks at the word being decoded, or the held word later on
	wire        at_decode  = (state_reg == oar_pkg::ST_DECODE) && pf_valid_reg;
	wire        at_long    = (state_reg == oar_pkg::ST_LONG) && pf_valid_reg;
	wire [15:0] cur_word   = (state_reg == oar_pkg::ST_DECODE) ? pf_word_reg : ir_reg;
	wire [3:0]  opc        = cur_word[oar_pkg::OPC_MSB:oar_pkg::OPC_LSB];
	wire        ind        = cur_word[oar_pkg::IND_BIT];
	wire [2:0]  mod_code   = cur_word[oar_pkg::MOD_MSB:oar_pkg::MOD_LSB];
	wire        arp_ld_bit = cur_word[oar_pkg::ARP_LD_BIT];
	wire [2:0]  imm3       = cur_word[oar_pkg::ARP_VAL_MSB:0];
	wire [2:0]  kind       = cur_word[oar_pkg::KIND_MSB:oar_pkg::KIND_LSB];

	wire is_mem    = (opc == oar_pkg::OPC_LOAD_MEM) || (opc == oar_pkg::OPC_RPT_MEM)
		|| (opc == oar_pkg::OPC_MULTI);
	wire is_target = (opc == oar_pkg::OPC_LOAD_MEM) || (opc == oar_pkg::OPC_MULTI);
	wire is_long   = (opc == oar_pkg::OPC_ADD_LONG) || (opc == oar_pkg::OPC_LOAD_AR);
	wire is_multi  = (opc == oar_pkg::OPC_MULTI);

	wire [15:0] direct_addr = {dp_reg, cur_word[oar_pkg::DIRECT_W-1:0]};
	wire [15:0] oper_addr   = ind ? cur_ar : direct_addr;

	// data handshake and the repeat pipeline
	wire data_done    = (state_reg == oar_pkg::ST_DATA) && i_data_ready;
	// repeated reads go out every cycle without waiting for the previous answer;
	// an external read is waited for, since the shared lines carry one at a time
	wire again        = (state_reg == oar_pkg::ST_DATA) && rpt_active && is_target
		&& (iss_left_reg != 16'h0000) && (!data_ext_reg || i_data_ready);
	wire more         = rpt_active && is_target && (rpt_cnt != 16'h0000);
	wire issue_rd     = (at_decode && is_mem) || again;
	wire rpt_step     = data_done && rpt_active && is_target;
	wire rpt_clear    = at_decode && rpt_active && !is_target;
	wire rpt_ld_short = at_decode && (opc == oar_pkg::OPC_RPT_SHORT);
	wire rpt_ld_mem   = data_done && (opc == oar_pkg::OPC_RPT_MEM);
	wire rpt_ld       = rpt_ld_short || rpt_ld_mem;
	wire [15:0] rpt_val = rpt_ld_mem ? i_data_rdata
		: {8'h00, cur_word[oar_pkg::SHORT_IMM_W-1:0]};

	// the address register unit sees only accesses made indirectly
	wire mod_en   = issue_rd && ind;
	wire arp_ld   = (mod_en && arp_ld_bit) || (at_decode && opc == oar_pkg::OPC_LOAD_ARP);
	wire ar_load  = at_long && (opc == oar_pkg::OPC_LOAD_AR);

	// prefetch: one buffered word, refilled as soon as it is used
	wire consume   = at_decode || at_long;
	wire issue_pf  = !pend_reg && (!pf_valid_reg || consume);
	wire pf_arrive = pend_reg && i_prog_ready;

	// short immediates come from the word itself, long from the next word
	wire        imm_short = at_decode && (opc == oar_pkg::OPC_ADD_SHORT);
	wire        imm_long  = at_long && (opc == oar_pkg::OPC_ADD_LONG);
	wire        op_out    = imm_short || imm_long || (data_done && is_target);
	wire [15:0] op_val    = imm_short ? {8'h00, cur_word[oar_pkg::SHORT_IMM_W-1:0]}
		: (imm_long ? pf_word_reg : i_data_rdata);

	// interrupts stay held from the repeat decode until the last iteration retires
	wire mask_next = rpt_ld_short || (at_decode && opc == oar_pkg::OPC_RPT_MEM)
		|| rpt_pend_reg || (rpt_active && !(rpt_step && rpt_cnt == 16'h0000)
		&& !rpt_clear);

	oar_addr_regs u_addr_regs (
		.i_clock             (i_clock),
		.i_rst               (i_rst),
		.i_mod_en            (mod_en),
		.i_mod               (mod_code),
		.i_arp_load          (arp_ld),
		.i_arp_val           (imm3),
		.i_load_en           (ar_load),
		.i_load_idx          (ir_reg[oar_pkg::ARP_VAL_MSB:0]),
		.i_load_val          (pf_word_reg),
		.o_addr_reg_selector (arp_now),
		.o_cur_ar            (cur_ar)
	);

	oar_repeat_ctrl u_repeat (
		.i_clock          (i_clock),
		.i_rst            (i_rst),
		.i_load           (rpt_ld),
		.i_load_val       (rpt_val),
		.i_step           (rpt_step),
		.i_clear          (rpt_clear),
		.o_repeat_counter (rpt_cnt),
		.o_active         (rpt_active)
	);

	localparam bit MULTI_PAD_NZ = (oar_pkg::MULTI_PAD != 2'h0);

	// next state; an operand read waits on ready, so external data costs cycles
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			oar_pkg::ST_DECODE:
			begin
				if (pf_valid_reg && is_long)
					state_next = oar_pkg::ST_LONG;
				else if (pf_valid_reg && is_mem)
					state_next = oar_pkg::ST_DATA;
			end
			oar_pkg::ST_LONG:
			begin
				if (pf_valid_reg)
					state_next = oar_pkg::ST_DECODE;
			end
			oar_pkg::ST_DATA:
			begin
				if (i_data_ready && !more)
				begin
					if (is_multi && !rpt_active && MULTI_PAD_NZ)
						state_next = oar_pkg::ST_MULTI;
					else
						state_next = oar_pkg::ST_DECODE;
				end
			end
			oar_pkg::ST_MULTI:
			begin
				if (pad_reg == 2'h1)
					state_next = oar_pkg::ST_DECODE;
			end
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_reg    <= oar_pkg::ST_DECODE;
			pc_reg       <= oar_pkg::PC_RST;
			pend_reg     <= 1'b0;
			pf_valid_reg <= 1'b0;
			pf_word_reg  <= 16'h0000;
			ir_reg       <= 16'h0000;
		end
		else
		begin
			state_reg <= state_next;
			if (issue_pf)
				pc_reg <= pc_reg + 16'h0001;
			pend_reg <= issue_pf | (pend_reg & ~i_prog_ready);
			if (pf_arrive)
			begin
				pf_valid_reg <= 1'b1;
				pf_word_reg  <= i_prog_word;
			end
			else if (consume)
				pf_valid_reg <= 1'b0;
			if (at_decode)
				ir_reg <= pf_word_reg;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			dp_reg       <= oar_pkg::DP_RST;
			pad_reg      <= 2'h0;
			rpt_pend_reg <= 1'b0;
			iss_left_reg <= 16'h0000;
		end
		else
		begin
			if (at_decode)
				iss_left_reg <= (rpt_active && is_target) ? rpt_cnt : 16'h0000;
			else if (again)
				iss_left_reg <= iss_left_reg - 16'h0001;
			if (at_decode && opc == oar_pkg::OPC_LOAD_DP)
				dp_reg <= cur_word[oar_pkg::DP_W-1:0];
			if (data_done && is_multi && !rpt_active)
				pad_reg <= oar_pkg::MULTI_PAD;
			else if (state_reg == oar_pkg::ST_MULTI)
				pad_reg <= pad_reg - 2'h1;
			rpt_pend_reg <= (at_decode && opc == oar_pkg::OPC_RPT_MEM)
				|| (rpt_pend_reg && !rpt_ld_mem);
		end
	end

	// every output is a flop
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			prog_addr_reg     <= 16'h0000;
			prog_rd_reg       <= 1'b0;
			data_addr_reg     <= 16'h0000;
			data_rd_reg       <= 1'b0;
			data_ext_reg      <= 1'b0;
			operand_reg       <= 16'h0000;
			operand_valid_reg <= 1'b0;
			multi_iter_reg    <= 1'b0;
			multi_kind_reg    <= 3'h0;
			int_mask_reg      <= 1'b0;
			rpt_cnt_reg       <= oar_pkg::RPT_RST;
			arp_out_reg       <= oar_pkg::ARP_RST;
		end
		else
		begin
			prog_rd_reg <= issue_pf;
			if (issue_pf)
				prog_addr_reg <= pc_reg;
			data_rd_reg <= issue_rd;
			if (issue_rd)
			begin
				data_addr_reg <= oper_addr;
				data_ext_reg  <= (oper_addr >= oar_pkg::INTERNAL_DATA_LIMIT);
			end
			operand_valid_reg <= op_out;
			if (op_out)
				operand_reg <= op_val;
			multi_iter_reg <= data_done && is_multi;
			if (data_done && is_multi)
				multi_kind_reg <= kind;
			int_mask_reg <= mask_next;
			rpt_cnt_reg  <= rpt_ld ? rpt_val : (rpt_step && rpt_cnt != 16'h0000)
				? rpt_cnt - 16'h0001 : rpt_cnt;
			arp_out_reg  <= arp_ld ? imm3 : arp_now;
		end
	end

	assign o_prog_addr         = prog_addr_reg;
	assign o_prog_rd           = prog_rd_reg;
	assign o_data_addr         = data_addr_reg;
	assign o_data_rd           = data_rd_reg;
	assign o_data_external     = data_ext_reg;
	assign o_operand           = operand_reg;
	assign o_operand_valid     = operand_valid_reg;
	assign o_multi_iter        = multi_iter_reg;
	assign o_multi_kind        = multi_kind_reg;
	assign o_int_mask          = int_mask_reg;
	assign o_repeat_counter    = rpt_cnt_reg;
	assign o_page_pointer      = dp_reg;
	assign o_addr_reg_selector = arp_out_reg;
endmodule

// ==== src/oar_pkg.sv ====
// constants, encodings and states shared by the operand address and repeat logic
package oar_pkg;
	localparam int WORD_W      = 16;
	localparam int DP_W        = 9;
	localparam int DIRECT_W    = 7;
	localparam int NUM_AR      = 8;
	localparam int ARP_W       = 3;
	localparam int SHORT_IMM_W = 8;
	localparam int KIND_W      = 3;

	// instruction word fields
	localparam int OPC_MSB     = 15;
	localparam int OPC_LSB     = 12;
	localparam int KIND_MSB    = 10;
	localparam int KIND_LSB    = 8;
	localparam int IND_BIT     = 7;
	localparam int MOD_MSB     = 6;
	localparam int MOD_LSB     = 4;
	localparam int ARP_LD_BIT  = 3;
	localparam int ARP_VAL_MSB = 2;

	// opcode classes (top nibble)
	localparam logic [3:0] OPC_NOP        = 4'h0;
	localparam logic [3:0] OPC_LOAD_DP    = 4'h1;
	localparam logic [3:0] OPC_LOAD_ARP   = 4'h2;
	localparam logic [3:0] OPC_LOAD_AR    = 4'h3;
	localparam logic [3:0] OPC_ADD_SHORT  = 4'h4;
	localparam logic [3:0] OPC_ADD_LONG   = 4'h5;
	localparam logic [3:0] OPC_LOAD_MEM   = 4'h6;
	localparam logic [3:0] OPC_RPT_SHORT  = 4'h7;
	localparam logic [3:0] OPC_RPT_MEM    = 4'h8;
	localparam logic [3:0] OPC_MULTI      = 4'h9;

	// kinds of the multicycle class, reported on each iteration
	localparam logic [2:0] KIND_MULTIPLY_ACCUMULATE_OP      = 3'h0;
	localparam logic [2:0] KIND_MULTIPLY_ACCUMULATE_MOVE_OP = 3'h1;
	localparam logic [2:0] KIND_DATA_BLOCK_MOVE_OP          = 3'h2;
	localparam logic [2:0] KIND_PROGRAM_TO_DATA_MOVE_OP     = 3'h3;
	localparam logic [2:0] KIND_IO_TRANSFER_OP              = 3'h4;
	localparam logic [2:0] KIND_TABLE_READ_OP               = 3'h5;
	localparam logic [2:0] KIND_TABLE_WRITE_OP              = 3'h6;

	// indirect modification codes
	localparam logic [2:0] MOD_NONE    = 3'h0;
	localparam logic [2:0] MOD_DEC     = 3'h1;
	localparam logic [2:0] MOD_INC     = 3'h2;
	localparam logic [2:0] MOD_SUB_AR0 = 3'h3;
	localparam logic [2:0] MOD_ADD_AR0 = 3'h4;
	localparam logic [2:0] MOD_REV_DEC = 3'h5;
	localparam logic [2:0] MOD_REV_INC = 3'h6;

	// reset values
	localparam logic [15:0] PC_RST  = 16'h0000;
	localparam logic [8:0]  DP_RST  = 9'h000;
	localparam logic [2:0]  ARP_RST = 3'h0;
	localparam logic [15:0] AR_RST  = 16'h0000;
	localparam logic [15:0] RPT_RST = 16'h0000;

	// data addresses at or above this limit go out over the shared lines
	localparam logic [15:0] INTERNAL_DATA_LIMIT = 16'h0400;
	// a multicycle op alone costs this many cycles, counted from decode
	localparam int          MULTI_CYCLES        = 3;
	localparam logic [1:0]  MULTI_PAD           = 2'(MULTI_CYCLES - 2);

	typedef enum logic [1:0] {ST_DECODE, ST_LONG, ST_DATA, ST_MULTI} oar_state_e;
endpackage

// ==== src/oar_addr_regs.sv ====
// eight indirect address registers, their selector and the per-access modification
module oar_addr_regs (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_mod_en,
	input  wire logic [2:0]  i_mod,
	input  wire logic        i_arp_load,
	input  wire logic [2:0]  i_arp_val,
	input  wire logic        i_load_en,
	input  wire logic [2:0]  i_load_idx,
	input  wire logic [15:0] i_load_val,
	output logic      [2:0]  o_addr_reg_selector,
	output logic      [15:0] o_cur_ar
);
	logic [2:0]  arp_reg;
	logic [15:0] ar_view [oar_pkg::NUM_AR];
	logic [15:0] modded;
	logic [15:0] rev_cur;
	logic [15:0] rev_ar0;

	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = 16'h0000;
		for (int k = 0; k < 16; k++)
			r[k] = v[15 - k];
		return r;
	endfunction

	assign o_addr_reg_selector = arp_reg;
	assign o_cur_ar            = ar_view[arp_reg];
	assign rev_cur             = rev16(o_cur_ar);
	assign rev_ar0             = rev16(ar_view[0]);

	// bit-reversed stepping carries from the msb downward, as fft indexing needs
	always_comb
	begin
		unique case (i_mod)
			oar_pkg::MOD_DEC:     modded = o_cur_ar - 16'h0001;
			oar_pkg::MOD_INC:     modded = o_cur_ar + 16'h0001;
			oar_pkg::MOD_SUB_AR0: modded = o_cur_ar - ar_view[0];
			oar_pkg::MOD_ADD_AR0: modded = o_cur_ar + ar_view[0];
			oar_pkg::MOD_REV_DEC: modded = rev16(rev_cur - rev_ar0);
			oar_pkg::MOD_REV_INC: modded = rev16(rev_cur + rev_ar0);
			default:              modded = o_cur_ar;
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < oar_pkg::NUM_AR; g++)
		begin : g_ar
			logic [15:0] val_reg;
			wire         hit_load = i_load_en && (i_load_idx == 3'(g));
			wire         hit_mod  = i_mod_en && (arp_reg == 3'(g));
			assign ar_view[g] = val_reg;
			always_ff @(posedge i_clock)
			begin
				if (i_rst)
					val_reg <= oar_pkg::AR_RST;
				else if (hit_load)
					val_reg <= i_load_val;
				else if (hit_mod)
					val_reg <= modded;
			end
		end
	endgenerate

	// the selector changes only after the access has used the old register
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			arp_reg <= oar_pkg::ARP_RST;
		else if (i_arp_load)
			arp_reg <= i_arp_val;
	end
endmodule

// ==== src/oar_repeat_ctrl.sv ====
// repeat counter: loaded by the repeat op, stepped once per completed iteration
module oar_repeat_ctrl (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_load,
	input  wire logic [15:0] i_load_val,
	input  wire logic        i_step,
	input  wire logic        i_clear,
	output logic      [15:0] o_repeat_counter,
	output logic             o_active
);
	logic [15:0] cnt_reg;
	logic        act_reg;

	assign o_repeat_counter = cnt_reg;
	assign o_active         = act_reg;

	// a count of n gives n further iterations after the first, n + 1 in all
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			cnt_reg <= oar_pkg::RPT_RST;
			act_reg <= 1'b0;
		end
		else if (i_load)
		begin
			cnt_reg <= i_load_val;
			act_reg <= 1'b1;
		end
		else if (i_clear || (i_step && cnt_reg == 16'h0000))
			act_reg <= 1'b0;
		else if (i_step)
			cnt_reg <= cnt_reg - 16'h0001;
	end
endmodule

// ==== bench/oar_core_chk.sv ====
// port-level assertions for the operand address and repeat core
module oar_core_chk (
	input wire logic        i_clock,
	input wire logic        i_rst,
	input wire logic        i_prog_ready,
	input wire logic [15:0] i_prog_word,
	input wire logic        i_data_ready,
	input wire logic [15:0] i_data_rdata,
	input wire logic [15:0] o_prog_addr,
	input wire logic        o_prog_rd,
	input wire logic [15:0] o_data_addr,
	input wire logic        o_data_rd,
	input wire logic        o_data_external,
	input wire logic [15:0] o_operand,
	input wire logic        o_operand_valid,
	input wire logic        o_multi_iter,
	input wire logic [2:0]  o_multi_kind,
	input wire logic        o_int_mask,
	input wire logic [15:0] o_repeat_counter,
	input wire logic [8:0]  o_page_pointer,
	input wire logic [2:0]  o_addr_reg_selector
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	logic        fetch_seen_reg;
	logic [15:0] fetch_last_reg;

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			fetch_seen_reg <= 1'b0;
			fetch_last_reg <= 16'h0000;
		end
		else if (o_prog_rd)
		begin
			fetch_seen_reg <= 1'b1;
			fetch_last_reg <= o_prog_addr;
		end
	end

	sequence s_fetch_open;
		o_prog_rd ##1 !i_prog_ready;
	endsequence

	sequence s_read_open;
		o_data_rd ##1 !i_data_ready;
	endsequence

	a_fetch_one_out: assert property (s_fetch_open |=> !o_prog_rd)
		else $error("second fetch issued while one was pending");
	a_read_one_out: assert property (s_read_open |=> !o_data_rd)
		else $error("second operand read issued while one was pending");
	a_fetch_step: assert property (
		o_prog_rd && fetch_seen_reg |-> o_prog_addr == fetch_last_reg + 16'h0001)
		else $error("fetch address did not step by one");
	a_first_fetch: assert property (
		$fell(i_rst) |-> ##[1:2] (o_prog_rd && o_prog_addr == 16'h0000))
		else $error("first fetch after reset missing");
	a_reset_clear: assert property (
		$fell(i_rst) |-> o_repeat_counter == 16'h0000 && !o_int_mask && o_page_pointer == 9'h000)
		else $error("state not cleared by reset");
	a_ext_flag: assert property (
		o_data_rd |-> o_data_external == (o_data_addr >= 16'h0400))
		else $error("external flag disagrees with operand address");
	a_daddr_stable: assert property (!o_data_rd |-> $stable(o_data_addr))
		else $error("operand address moved without a read");
	a_mask_end: assert property (
		$fell(o_int_mask) |-> ##[0:2] (o_repeat_counter == 16'h0000))
		else $error("repeat loop ended with counter left over");
	a_iter_masked: assert property (
		o_multi_iter && o_repeat_counter != 16'h0000 |-> o_int_mask)
		else $error("iteration of a repeat loop ran unmasked");
endmodule

bind oar_core oar_core_chk i_oar_core_chk (.i_clock(i_clock), .i_rst(i_rst),
	.i_prog_ready(i_prog_ready), .i_prog_word(i_prog_word), .i_data_ready(i_data_ready),
	.i_data_rdata(i_data_rdata), .o_prog_addr(o_prog_addr), .o_prog_rd(o_prog_rd),
	.o_data_addr(o_data_addr), .o_data_rd(o_data_rd), .o_data_external(o_data_external),
	.o_operand(o_operand), .o_operand_valid(o_operand_valid), .o_multi_iter(o_multi_iter),
	.o_multi_kind(o_multi_kind), .o_int_mask(o_int_mask),
	.o_repeat_counter(o_repeat_counter), .o_page_pointer(o_page_pointer),
	.o_addr_reg_selector(o_addr_reg_selector));

// ==== bench/oar_mem_model.sv ====
// program and data memory on the far side of the operand address core
module oar_mem_model #(
	parameter int EXT_WAIT = 3
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_prog_rd,
	input  wire logic [15:0] i_prog_addr,
	input  wire logic        i_data_rd,
	input  wire logic [15:0] i_data_addr,
	output logic             o_prog_ready,
	output logic      [15:0] o_prog_word,
	output logic             o_data_ready,
	output logic      [15:0] o_data_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] prog [0:255];
	logic [15:0] addr_hold;
	int          wait_cnt;

	initial
	begin
		o_prog_ready = 1'b0;
		o_data_ready = 1'b0;
		o_prog_word = 16'h0000;
		o_data_rdata = 16'h0000;
		addr_hold = 16'h0000;
		wait_cnt = 0;
	end

	// released lines flip every cycle between the last word and its inverse, so stale data never stays steady
	always @(posedge i_clock)
	begin
		o_prog_ready <= i_prog_rd && !i_rst;
		o_prog_word <= i_prog_rd ? prog[i_prog_addr[7:0]] : ~o_prog_word;
		o_data_ready <= 1'b0;
		o_data_rdata <= ~o_data_rdata;
		if (!i_rst && i_data_rd && i_data_addr < 16'h0400)
		begin
			o_data_ready <= 1'b1;
			o_data_rdata <= i_data_addr ^ 16'h5a5a;
		end
		else if (!i_rst && wait_cnt == 1)
		begin
			o_data_ready <= 1'b1;
			o_data_rdata <= addr_hold ^ 16'h5a5a;
		end
		if (i_rst)
			wait_cnt <= 0;
		else if (i_data_rd)
		begin
			addr_hold <= i_data_addr;
			wait_cnt <= (i_data_addr >= 16'h0400) ? EXT_WAIT : 0;
		end
		else if (wait_cnt != 0)
			wait_cnt <= wait_cnt - 1;
	end
endmodule

// ==== bench/oar_core_tb.sv ====
// self-checking bench for the operand address and repeat core
module oar_core_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        i_clock = 1'b0;
	logic        i_rst = 1'b1;
	logic        prog_ready, data_ready, prog_rd, data_rd, data_ext, op_valid, multi_iter;
	logic        int_mask;
	logic [15:0] prog_word, data_rdata, prog_addr, data_addr, operand, rep_count;
	logic [8:0]  page;
	logic [2:0]  multi_kind, selector;
	logic [31:0] rd_q[$], op_q[$], it_q[$];
	int          cyc = 0;
	int          mismatches = 0;
	int          checks_done = 0;
	logic [15:0] words [0:29] = '{16'h1005, 16'h6012, 16'h2003, 16'h3003, 16'h0500,
		16'h3000, 16'h0010, 16'h60a0, 16'h6090, 16'h60c0, 16'h60b0, 16'h60e0, 16'h60d0,
		16'h6089, 16'h6080, 16'h40ab, 16'h5000, 16'h1234, 16'h7002, 16'h90a0, 16'h9101,
		16'h9202, 16'h9303, 16'h9404, 16'h9505, 16'h9606, 16'h10b4, 16'h805b, 16'h6080,
		16'h0000};

	oar_core i_oar_core (.i_clock(i_clock), .i_rst(i_rst), .i_prog_ready(prog_ready),
		.i_prog_word(prog_word), .i_data_ready(data_ready), .i_data_rdata(data_rdata),
		.o_prog_addr(prog_addr), .o_prog_rd(prog_rd), .o_data_addr(data_addr),
		.o_data_rd(data_rd), .o_data_external(data_ext), .o_operand(operand),
		.o_operand_valid(op_valid), .o_multi_iter(multi_iter), .o_multi_kind(multi_kind),
		.o_int_mask(int_mask), .o_repeat_counter(rep_count), .o_page_pointer(page),
		.o_addr_reg_selector(selector));

	oar_mem_model i_oar_mem_model (.i_clock(i_clock), .i_rst(i_rst), .i_prog_rd(prog_rd),
		.i_prog_addr(prog_addr), .i_data_rd(data_rd), .i_data_addr(data_addr),
		.o_prog_ready(prog_ready), .o_prog_word(prog_word), .o_data_ready(data_ready),
		.o_data_rdata(data_rdata));

	always #10 i_clock = ~i_clock;

	// events are queued so that overlapping pipeline activity is never missed
	always @(posedge i_clock)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			mismatches++;
			report_and_stop();
		end
		if (!i_rst && data_rd)
			rd_q.push_back({15'h0000, data_ext, data_addr});
		if (!i_rst && op_valid)
			op_q.push_back({16'h0000, operand});
		if (!i_rst && multi_iter)
			it_q.push_back({cyc[27:0], int_mask, multi_kind});
	end

	function automatic logic [31:0] exp_rd(input logic [15:0] a);
		return {15'h0000, a >= 16'h0400, a};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic take(ref logic [31:0] q[$], output logic [31:0] v);
		int k;
		v = 32'hffffffff;
		for (k = 0; k < 100 && q.size() == 0; k++)
			@(posedge i_clock);
		if (q.size() != 0)
			v = q.pop_front();
	endtask

	task automatic expect_next(ref logic [31:0] q[$], input logic [31:0] exp);
		logic [31:0] v;
		take(q, v);
		check(v, exp);
	endtask

	task automatic sc_addressing();
		logic [15:0] a [0:7] = '{16'h0500, 16'h0501, 16'h0500, 16'h0510, 16'h0500,
			16'h0510, 16'h0500, 16'h0000};
		int          k;
		expect_next(rd_q, exp_rd(16'h0292));
		expect_next(op_q, 32'h000058c8);
		for (k = 0; k < 8; k++)
		begin
			expect_next(rd_q, exp_rd(a[k]));
			expect_next(op_q, {16'h0000, a[k] ^ 16'h5a5a});
		end
		check(32'(selector), 32'h1);
		expect_next(op_q, 32'h000000ab);
		expect_next(op_q, 32'h00001234);
	endtask

	task automatic sc_repeat_multi();
		logic [31:0] v;
		logic [31:0] prev;
		int          k;
		prev = 32'h0;
		for (k = 0; k < 3; k++)
		begin
			expect_next(rd_q, exp_rd(16'(k)));
			take(it_q, v);
			check(32'(v[3:0]), (k < 2) ? 32'h8 : 32'h0);
			if (k > 0)
				check(32'(v[31:4] - prev[31:4]), 32'h1);
			prev = v;
		end
		for (k = 1; k < 7; k++)
		begin
			expect_next(rd_q, exp_rd(16'h0280 + 16'(k)));
			take(it_q, v);
			check(32'(v[3:0]), 32'(k));
			if (k > 1)
				check(32'(v[31:4] - prev[31:4] >= 28'(oar_pkg::MULTI_CYCLES)), 32'h1);
			prev = v;
		end
	endtask

	task automatic sc_repeat_mem();
		expect_next(rd_q, exp_rd(16'h5a5b));
		expect_next(rd_q, exp_rd(16'h0003));
		expect_next(rd_q, exp_rd(16'h0003));
		repeat (20) @(posedge i_clock);
		check(32'(rd_q.size()), 32'h0);
		check(32'(int_mask), 32'h0);
		check(32'(page), 32'h000000b4);
	endtask

	task automatic pulse_reset();
		#1;
		i_rst = 1'b1;
		repeat (2) @(posedge i_clock);
		#1;
		check(32'(rep_count), 32'h0);
		check(32'(int_mask), 32'h0);
		check(32'(page), 32'h0);
		i_rst = 1'b0;
	endtask

	task automatic sc_reset();
		int k;
		pulse_reset();
		for (k = 0; k < 300 && int_mask !== 1'b1; k++)
		begin
			@(posedge i_clock);
			#1;
		end
		check(32'(int_mask), 32'h1);
		pulse_reset();
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		for (int k = 0; k < 256; k++)
			i_oar_mem_model.prog[k] = (k < 30) ? words[k] : 16'h0000;
		repeat (12) @(posedge i_clock);
		#1;
		i_rst = 1'b0;
		sc_addressing();
		sc_repeat_multi();
		sc_repeat_mem();
		sc_reset();
		report_and_stop();
	end
endmodule
